/* File: cmb_can_ctl.v */
// Operation mode, wake latch and bus failure control of a fault-tolerant CAN transceiver.
// What this block does
// - Watchdog reset in active modes forces stand-by.
// - Watchdog reset in stand-by keeps stand-by.
// - Sleep: regulator off, wake event goes stand-by.
// - Stand-by: receive output low flags captured wake.
// - Leaving stand-by for active mode clears latch.
// - Receive-only passes traffic, never drives bus.
// - Low termination to regulator or battery by mode.
// - Nine failure cases form seven failure groups.
// - Single-wire mode entered only after filter delay.
// - Differential mode resumes after further delay.
// - Cases 1,2,3a,4 keep differential reception.
// - Cases 3,5,6,6a,7 disable the faulty wire.
// - Receive mux picks healthy line's comparator simultaneously.
// - Normal diagnosis: high and low fail bits.
// - Receive-only diagnosis distinguishes six failure groups.
// - Failure flags held until next frame starts.
// - Long dominant transmit disables both drivers.
// - Over-temperature disables that driver, reception continues.
// - Sleep disables the voltage regulator.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "cmb_defines.vh"
module cmb_can_ctl #(
  parameter FCW = 16,
  parameter [FCW-1:0] FAIL_ON_CYC = `CMB_FAIL_ON_CYC,
  parameter [FCW-1:0] FAIL_OFF_CYC = `CMB_FAIL_OFF_CYC,
  parameter TCW = 16,
  parameter [TCW-1:0] TXD_TIMEOUT_CYC = `CMB_TXD_TIMEOUT_CYC
) (
  // Clock, reset and enable
  input wire clk_sys,
  input wire rst_b,
  input wire clk_en,
  // AXI4-Lite write address and data
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Protocol controller side
  input wire txd,
  output reg rxd,
  // Wake and watchdog events
  input wire wake1_in,
  input wire wake2_in,
  input wire bus_wake_in,
  input wire wd_reset_in,
  // Analog front end: comparators, failure detectors, thermal sensors
  input wire cmp_diff_dom,
  input wire cmp_high_dom,
  input wire cmp_low_dom,
  input wire [8:0] fail_case_in,
  input wire overtemp_high,
  input wire overtemp_low,
  // Driver, termination, multiplexer and regulator controls
  output reg tx_dominant,
  output reg high_drv_en,
  output reg low_drv_en,
  output reg high_term_en,
  output reg low_term_en,
  output reg low_line_termination_output_to_vcc,
  output reg low_line_termination_output_to_vbat,
  output reg high_line_termination_input_to_gnd,
  output reg [1:0] rx_mux_sel,
  output reg vreg_en
);

  // Synchronised pins: bit 0 is transmit data, dominant low.
  wire [9:0] pin_raw;
  wire [9:0] pin_s;
  wire [6:0] grp_raw;
  wire [6:0] grp_f;

  assign pin_raw = {cmp_low_dom, cmp_high_dom, cmp_diff_dom, overtemp_low, overtemp_high,
                    wd_reset_in, bus_wake_in, wake2_in, wake1_in, txd};

  // Cases are indexed 0..8 as 1,2,3,3a,4,5,6,6a,7.
  // Groups: 0={1,3a} 1={3} 2={2,4} 3={6a} 4={6} 5={5} 6={7}.
  assign grp_raw = {fail_case_in[8], fail_case_in[5], fail_case_in[6], fail_case_in[7],
                    fail_case_in[1] | fail_case_in[4], fail_case_in[2],
                    fail_case_in[0] | fail_case_in[3]};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1) begin : g_pin
      cmb_fail_filter #(
        .CW(FCW),
        .ON_CYC(`CMB_SYNC_CYC),
        .OFF_CYC(`CMB_SYNC_CYC),
        .INIT(gi == 0)
      ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .raw_in(pin_raw[gi]),
        .filt_out(pin_s[gi])
      );
    end
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_grp
      cmb_fail_filter #(
        .CW(FCW),
        .ON_CYC(FAIL_ON_CYC),
        .OFF_CYC(FAIL_OFF_CYC),
        .INIT(1'b0)
      ) u_filt (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .raw_in(grp_raw[gi]),
        .filt_out(grp_f[gi])
      );
    end
  endgenerate

  wire txd_s = pin_s[0];
  wire wake_any = pin_s[1] | pin_s[2] | pin_s[3];
  wire wd_s = pin_s[4];
  wire ot_high_s = pin_s[5];
  wire ot_low_s = pin_s[6];

  // Control and state registers.
  reg [1:0] mode_reg;
  reg [3:1] ctrl_reg;
  reg wake_latch_reg;
  reg wake_bus_reg;
  reg clr_armed_reg;
  reg wd_prev_reg;
  reg wd_flag_reg;
  reg txd_prev_reg;
  reg [TCW-1:0] txd_cnt_reg;
  reg txd_to_reg;
  reg [6:0] rep_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_got_reg;
  reg w_got_reg;

  wire wd_event = wd_s & ~wd_prev_reg;
  wire frame_start = txd_prev_reg & ~txd_s;
  wire active = (mode_reg == `CMB_MODE_NORMAL) || (mode_reg == `CMB_MODE_RXONLY);
  // Unbracketed case numbers: 1, 3, 3a and 5 hit the low line; 2, 4, 6 and 6a the high line.
  wire high_dis = grp_f[3] | grp_f[4];
  wire low_dis = grp_f[1] | grp_f[5] | grp_f[6];
  wire high_fail = rep_reg[2] | rep_reg[3] | rep_reg[4];
  wire low_fail = rep_reg[0] | rep_reg[1] | rep_reg[5] | rep_reg[6];

  // Register write decode.
  wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire && awaddr_reg == `CMB_OFF_CTRL && wstrb_reg[0];
  wire [3:1] wr_bits = wdata_reg[3:1];
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire rd_diag = rd_fire && s_axi_araddr == `CMB_OFF_DIAG;

  // Mode requested by the control word.
  reg [1:0] req_mode;
  always @* begin
    case ({wr_bits[`CMB_CTRL_NOT_STANDBY], wr_bits[`CMB_CTRL_TX_ENABLE]})
      2'b11: req_mode = `CMB_MODE_NORMAL;
      2'b10: req_mode = `CMB_MODE_RXONLY;
      2'b01: req_mode = `CMB_MODE_STANDBY;
      default: req_mode = `CMB_MODE_SLEEP;
    endcase
  end

  // Diagnosis word depends on the operation mode.
  reg [7:0] diag;
  always @* begin
    case (mode_reg)
      `CMB_MODE_NORMAL: begin
        diag = {2'b00, low_fail, high_fail, pin_s[2], pin_s[1], wd_flag_reg, 1'b0};
      end
      `CMB_MODE_RXONLY: begin
        diag = {rep_reg[5] | rep_reg[6], rep_reg[4], rep_reg[3], rep_reg[2], rep_reg[1],
                rep_reg[0], wd_flag_reg, 1'b0};
      end
      `CMB_MODE_STANDBY: begin
        diag = {3'b000, wake_bus_reg, pin_s[2], pin_s[1], wd_flag_reg, 1'b0};
      end
      default: begin
        diag = 8'h00;
      end
    endcase
  end

  // Mode machine and wake latch.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `CMB_MODE_RESET;
      ctrl_reg <= `CMB_CTRL_RESET;
      wake_latch_reg <= 1'b0;
      wake_bus_reg <= 1'b0;
      clr_armed_reg <= 1'b0;
      wd_prev_reg <= 1'b0;
      wd_flag_reg <= 1'b0;
    end else if (clk_en) begin
      wd_prev_reg <= wd_s;
      if (wd_event) begin
        // Watchdog reset clears the control word and parks the node in stand-by, except in sleep, which it keeps.
        ctrl_reg <= `CMB_CTRL_RESET;
        clr_armed_reg <= 1'b0;
        if (mode_reg != `CMB_MODE_SLEEP) begin
          mode_reg <= `CMB_MODE_STANDBY;
        end
      end else if (mode_reg == `CMB_MODE_SLEEP) begin
        if (wake_any) begin
          mode_reg <= `CMB_MODE_STANDBY;
        end
      end else if (wr_ctrl) begin
        ctrl_reg <= wr_bits;
        if (wr_bits[`CMB_CTRL_WAKE_CLR]) begin
          clr_armed_reg <= 1'b1;
        end else begin
          clr_armed_reg <= 1'b0;
        end
        // A pending wake keeps the node awake until software clears the latch.
        if (req_mode != `CMB_MODE_SLEEP || !wake_latch_reg) begin
          mode_reg <= req_mode;
        end
      end
      if (wd_event || (rd_diag && !wd_s)) begin
        wd_flag_reg <= wd_event;
      end
      // In stand-by, a wake arriving with a clear keeps the latch set.
      if (!active && wake_any) begin
        wake_latch_reg <= 1'b1;
        wake_bus_reg <= wake_bus_reg | pin_s[3];
      end else if (wr_ctrl && !wd_event && mode_reg == `CMB_MODE_STANDBY &&
                   (req_mode == `CMB_MODE_NORMAL || req_mode == `CMB_MODE_RXONLY)) begin
        wake_latch_reg <= 1'b0;
        wake_bus_reg <= 1'b0;
      end else if (wr_ctrl && !wd_event && mode_reg != `CMB_MODE_SLEEP &&
                   clr_armed_reg && !wr_bits[`CMB_CTRL_WAKE_CLR]) begin
        wake_latch_reg <= 1'b0;
        wake_bus_reg <= 1'b0;
      end
    end
  end

  // Failure reporting and transmit timeout.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txd_prev_reg <= 1'b1;
      txd_cnt_reg <= {TCW{1'b0}};
      txd_to_reg <= 1'b0;
      rep_reg <= 7'h00;
    end else if (clk_en) begin
      txd_prev_reg <= txd_s;
      // A present failure re-sets its flag even at a frame start.
      if (frame_start) begin
        rep_reg <= grp_f;
      end else begin
        rep_reg <= rep_reg | grp_f;
      end
      if (txd_s) begin
        txd_cnt_reg <= {TCW{1'b0}};
        txd_to_reg <= 1'b0;
      end else if (txd_cnt_reg >= TXD_TIMEOUT_CYC - {{(TCW-1){1'b0}}, 1'b1}) begin
        txd_to_reg <= 1'b1;
      end else begin
        txd_cnt_reg <= txd_cnt_reg + {{(TCW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Output stage controls, all registered.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rxd <= 1'b1;
      tx_dominant <= 1'b0;
      high_drv_en <= 1'b0;
      low_drv_en <= 1'b0;
      high_term_en <= 1'b1;
      low_term_en <= 1'b1;
      low_line_termination_output_to_vcc <= 1'b0;
      low_line_termination_output_to_vbat <= 1'b1;
      high_line_termination_input_to_gnd <= 1'b1;
      rx_mux_sel <= `CMB_MUX_DIFF;
      vreg_en <= 1'b1;
    end else if (clk_en) begin
      // Only normal mode may drive; receive-only cannot even acknowledge.
      high_drv_en <= mode_reg == `CMB_MODE_NORMAL && !txd_to_reg && !ot_high_s &&
                     !high_dis;
      low_drv_en <= mode_reg == `CMB_MODE_NORMAL && !txd_to_reg && !ot_low_s &&
                    !low_dis;
      tx_dominant <= mode_reg == `CMB_MODE_NORMAL && !txd_s && !txd_to_reg;
      high_term_en <= !high_dis;
      low_term_en <= !low_dis;
      low_line_termination_output_to_vcc <= active;
      low_line_termination_output_to_vbat <= !active;
      high_line_termination_input_to_gnd <= 1'b1;
      vreg_en <= mode_reg != `CMB_MODE_SLEEP;
      // The mux follows the same filtered groups that disable a wire.
      if (high_dis && !low_dis) begin
        rx_mux_sel <= `CMB_MUX_LOW;
      end else if (low_dis && !high_dis) begin
        rx_mux_sel <= `CMB_MUX_HIGH;
      end else begin
        rx_mux_sel <= `CMB_MUX_DIFF;
      end
      // Reception works in active modes regardless of thermal shutdown.
      case (mode_reg)
        `CMB_MODE_NORMAL, `CMB_MODE_RXONLY: begin
          if (high_dis && !low_dis) begin
            rxd <= !pin_s[9];
          end else if (low_dis && !high_dis) begin
            rxd <= !pin_s[8];
          end else begin
            rxd <= !pin_s[7];
          end
        end
        `CMB_MODE_STANDBY: begin
          rxd <= !wake_latch_reg;
        end
        default: begin
          rxd <= 1'b0;
        end
      endcase
    end
  end

  // AXI4-Lite slave.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMB_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMB_RESP_OKAY;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_got_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_got_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Status and diagnosis are read-only; writes to them are refused.
        s_axi_bresp <= (awaddr_reg == `CMB_OFF_CTRL) ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CMB_RESP_OKAY;
        case (s_axi_araddr)
          `CMB_OFF_CTRL: s_axi_rdata <= {28'h0000000, ctrl_reg, 1'b0};
          `CMB_OFF_STATUS: s_axi_rdata <= {14'h0000, rep_reg, grp_f, txd_to_reg,
                                           wake_latch_reg, mode_reg};
          `CMB_OFF_DIAG: s_axi_rdata <= {24'h000000, diag};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CMB_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: cmb_can_ctl_chk.sv */
// Port assertions for the CAN mode and bus failure control block.
`timescale 1ns/100ps
`include "cmb_defines.vh"
module cmb_can_ctl_chk #(
  parameter TXD_TIMEOUT_CYC = 20
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_b,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Transceiver controls
  input wire txd,
  input wire rxd,
  input wire tx_dominant,
  input wire high_drv_en,
  input wire low_drv_en,
  input wire high_term_en,
  input wire low_term_en,
  input wire low_line_termination_output_to_vcc,
  input wire low_line_termination_output_to_vbat,
  input wire high_line_termination_input_to_gnd,
  input wire [1:0] rx_mux_sel,
  input wire vreg_en
);
  reg [15:0] dom_cnt_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Counts raw dominant cycles; the margin covers the pin synchroniser.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) dom_cnt_reg <= 16'h0000;
    else if (txd) dom_cnt_reg <= 16'h0000;
    else if (dom_cnt_reg != 16'hffff) dom_cnt_reg <= dom_cnt_reg + 16'h0001;
  end
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  AST_B_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_SLEEP_RXD: assert property (!vreg_en |-> !rxd)
    else $error("receive output not low in sleep");
  AST_SLEEP_DRV: assert property (!vreg_en |-> !high_drv_en && !low_drv_en && !tx_dominant)
    else $error("driver active in sleep");
  AST_TERM_SWITCH: assert property (low_line_termination_output_to_vcc ^
    low_line_termination_output_to_vbat) else $error("low termination switch not one-hot");
  AST_HIGH_TERM_GND: assert property (high_line_termination_input_to_gnd)
    else $error("high termination not grounded");
  AST_MUX_HIGH: assert property (rx_mux_sel == `CMB_MUX_HIGH |-> !low_term_en && !low_drv_en)
    else $error("low wire active while high comparator selected");
  AST_MUX_LOW: assert property (rx_mux_sel == `CMB_MUX_LOW |-> !high_term_en && !high_drv_en)
    else $error("high wire active while low comparator selected");
  AST_TXD_TIMEOUT: assert property (dom_cnt_reg > TXD_TIMEOUT_CYC + 8
    |-> !tx_dominant && !high_drv_en && !low_drv_en) else $error("drivers on after timeout");
endmodule

/* File: cmb_can_ctl_tb.sv */
// Self-checking testbench for the CAN mode and bus failure control block.
`timescale 1ns/100ps
`include "cmb_defines.vh"
module cmb_can_ctl_tb;
  reg clk_sys = 1'b0, rst_b = 1'b0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg [31:0] s_axi_wdata = 32'h0;
  reg txd_stuck = 0, send = 0, wake1_in = 0, wake2_in = 0, bus_wake_in = 0, wd_reset_in = 0;
  reg cmp_diff_dom = 0, cmp_high_dom = 0, overtemp_high = 0, cmp_low_dom = 0, overtemp_low = 0;
  reg [8:0] fail_case_in = 9'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, rxd;
  wire tx_dominant, high_drv_en, low_drv_en, high_term_en, low_term_en, vreg_en;
  wire low_line_termination_output_to_vcc, low_line_termination_output_to_vbat;
  wire high_line_termination_input_to_gnd;
  wire [1:0] s_axi_bresp, s_axi_rresp, rx_mux_sel;
  wire [31:0] s_axi_rdata;
  integer bad_count = 0, checked = 0, cyc = 0, i;

  always #10 clk_sys = ~clk_sys;

  // Short counts keep the failure filters and the timeout quick to exercise.
  cmb_can_ctl #(.FAIL_ON_CYC(16'h0004), .FAIL_OFF_CYC(16'h0008), .TXD_TIMEOUT_CYC(16'h0014))
    u_cmb_can_ctl (.clk_sys, .rst_b, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd, .rxd, .wake1_in,
    .wake2_in, .bus_wake_in, .wd_reset_in, .cmp_diff_dom, .cmp_high_dom, .cmp_low_dom,
    .fail_case_in, .overtemp_high, .overtemp_low, .tx_dominant, .high_drv_en,
    .low_drv_en, .high_term_en, .low_term_en, .low_line_termination_output_to_vcc,
    .low_line_termination_output_to_vbat, .high_line_termination_input_to_gnd, .rx_mux_sel,
    .vreg_en);

  cmb_proto_model u_cmb_proto_model (.clk_sys, .send, .stuck_dom(txd_stuck), .txd);

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask

  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      $display("MISMATCH run length expected below 20000 seen 20000");
      finish_test;
    end
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task settle(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask

  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      done = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
        @(posedge clk_sys);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) begin
          done = 1;
          s_axi_bready <= 1'b0;
          chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        end
      end
    end
  endtask

  task rdc(input [11:0] a, input [31:0] m, input [31:0] e, input [1:0] er);
    reg done;
    begin
      done = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
        @(posedge clk_sys);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) begin
          done = 1;
          s_axi_rready <= 1'b0;
          chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
          chk("rdata", e, s_axi_rdata & m);
        end
      end
    end
  endtask

  task frame;
    begin
      @(posedge clk_sys);
      send <= 1'b1;
      @(posedge clk_sys);
      send <= 1'b0;
      settle(60);
    end
  endtask

  task pulse(input integer k);
    begin
      @(posedge clk_sys);
      wake1_in <= (k == 0);
      wake2_in <= (k == 1);
      bus_wake_in <= (k == 2);
      wd_reset_in <= (k == 3);
      settle(8);
      {wake1_in, wake2_in, bus_wake_in, wd_reset_in} <= 4'h0;
      settle(8);
    end
  endtask

  initial begin
    settle(10);
    rst_b <= 1'b1;
    settle(2);
    rdc(`CMB_OFF_STATUS, 32'h3, {30'h0, `CMB_MODE_RESET}, `CMB_RESP_OKAY);
    chk("rxd", 1, rxd);
    rdc(`CMB_OFF_CTRL, 32'hffffffff, 32'h0, `CMB_RESP_OKAY);
    rdc(12'h00c, 32'hffffffff, 32'h0, `CMB_RESP_SLVERR);
    wr(`CMB_OFF_STATUS, 32'h3, `CMB_RESP_SLVERR);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CMB_OFF_CTRL, 32'hc - 4 * i, `CMB_RESP_OKAY);
      rdc(`CMB_OFF_STATUS, 32'h3, (i == 0) ? `CMB_MODE_NORMAL : (i == 1) ? `CMB_MODE_RXONLY :
        `CMB_MODE_STANDBY, `CMB_RESP_OKAY);
      chk("to_vcc", i < 2, low_line_termination_output_to_vcc);
    end
    wr(`CMB_OFF_CTRL, 32'hc, `CMB_RESP_OKAY);
    txd_stuck <= 1'b1;
    settle(10);
    chk("tx_dominant", 1, tx_dominant);
    settle(30);
    chk("drivers", 0, {tx_dominant, high_drv_en, low_drv_en});
    rdc(`CMB_OFF_STATUS, 32'h8, 32'h8, `CMB_RESP_OKAY);
    txd_stuck <= 1'b0;
    overtemp_high <= 1'b1;
    cmp_diff_dom <= 1'b1;
    settle(10);
    chk("drv_en", 1, {high_drv_en, low_drv_en});
    chk("rxd", 0, rxd);
    overtemp_high <= 1'b0;
    overtemp_low <= 1'b1;
    settle(10);
    chk("drv_en", 2, {high_drv_en, low_drv_en});
    overtemp_low <= 1'b0;
    wr(`CMB_OFF_CTRL, 32'h8, `CMB_RESP_OKAY);
    txd_stuck <= 1'b1;
    settle(10);
    chk("rx-only drive", 0, {tx_dominant, high_drv_en, low_drv_en});
    chk("rxd", 0, rxd);
    txd_stuck <= 1'b0;
    cmp_diff_dom <= 1'b0;
    fail_case_in <= 9'h004;
    cmp_high_dom <= 1'b1;
    settle(30);
    chk("mux", `CMB_MUX_HIGH, rx_mux_sel);
    chk("rxd", 0, rxd);
    rdc(`CMB_OFF_DIAG, 32'hfc, 32'h08, `CMB_RESP_OKAY);
    fail_case_in <= 9'h000;
    cmp_high_dom <= 1'b0;
    settle(30);
    wr(`CMB_OFF_CTRL, 32'hc, `CMB_RESP_OKAY);
    frame;
    rdc(`CMB_OFF_DIAG, 32'h30, 32'h0, `CMB_RESP_OKAY);
    fail_case_in <= 9'h040;
    settle(2);
    fail_case_in <= 9'h000;
    settle(20);
    chk("mux", `CMB_MUX_DIFF, rx_mux_sel);
    fail_case_in <= 9'h008;
    settle(30);
    chk("diff kept", {`CMB_MUX_DIFF, 2'h3}, {rx_mux_sel, high_term_en, low_term_en});
    rdc(`CMB_OFF_DIAG, 32'h30, 32'h20, `CMB_RESP_OKAY);
    fail_case_in <= 9'h040;
    cmp_low_dom <= 1'b1;
    settle(3);
    chk("mux", `CMB_MUX_DIFF, rx_mux_sel);
    settle(27);
    chk("single wire", {`CMB_MUX_LOW, 2'h0}, {rx_mux_sel, high_term_en, rxd});
    rdc(`CMB_OFF_DIAG, 32'h30, 32'h30, `CMB_RESP_OKAY);
    fail_case_in <= 9'h000;
    cmp_low_dom <= 1'b0;
    settle(8);
    chk("mux", `CMB_MUX_LOW, rx_mux_sel);
    settle(30);
    chk("mux", `CMB_MUX_DIFF, rx_mux_sel);
    rdc(`CMB_OFF_DIAG, 32'h30, 32'h30, `CMB_RESP_OKAY);
    frame;
    rdc(`CMB_OFF_DIAG, 32'h30, 32'h0, `CMB_RESP_OKAY);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CMB_OFF_CTRL, 32'h6, `CMB_RESP_OKAY);
      wr(`CMB_OFF_CTRL, 32'h4, `CMB_RESP_OKAY);
      wr(`CMB_OFF_CTRL, 32'h0, `CMB_RESP_OKAY);
      settle(4);
      chk("sleep", 0, {vreg_en, rxd});
      pulse(i);
      rdc(`CMB_OFF_STATUS, 32'h3, `CMB_MODE_STANDBY, `CMB_RESP_OKAY);
      chk("woken", 2, {vreg_en, rxd});
      wr(`CMB_OFF_CTRL, 32'h0, `CMB_RESP_OKAY);
      rdc(`CMB_OFF_STATUS, 32'h3, `CMB_MODE_STANDBY, `CMB_RESP_OKAY);
    end
    wr(`CMB_OFF_CTRL, 32'hc, `CMB_RESP_OKAY);
    rdc(`CMB_OFF_STATUS, 32'h7, `CMB_MODE_NORMAL, `CMB_RESP_OKAY);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CMB_OFF_CTRL, 32'hc - 4 * i, `CMB_RESP_OKAY);
      pulse(3);
      rdc(`CMB_OFF_STATUS, 32'h3, `CMB_MODE_STANDBY, `CMB_RESP_OKAY);
      rdc(`CMB_OFF_CTRL, 32'he, 32'h0, `CMB_RESP_OKAY);
    end
    finish_test;
  end
endmodule

bind cmb_can_ctl cmb_can_ctl_chk #(.TXD_TIMEOUT_CYC(TXD_TIMEOUT_CYC)) u_cmb_can_ctl_chk (
  .clk_sys, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .txd, .rxd, .tx_dominant,
  .high_drv_en, .low_drv_en, .high_term_en, .low_term_en, .low_line_termination_output_to_vcc,
  .low_line_termination_output_to_vbat, .high_line_termination_input_to_gnd, .rx_mux_sel,
  .vreg_en);

/* File: cmb_defines.vh */
// Constants for the CAN mode and bus failure control block.
`ifndef CMB_DEFINES_VH
`define CMB_DEFINES_VH

// System clock rate.
`define CMB_CLK_MHZ 50

// Failure filter delays, as times and as cycle counts.
`define CMB_FAIL_ON_US 30
`define CMB_FAIL_ON_CYC (`CMB_FAIL_ON_US * `CMB_CLK_MHZ)
`define CMB_FAIL_OFF_US 60
`define CMB_FAIL_OFF_CYC (`CMB_FAIL_OFF_US * `CMB_CLK_MHZ)

// Transmit-dominant timeout, as a time and as a cycle count.
`define CMB_TXD_TIMEOUT_US 1000
`define CMB_TXD_TIMEOUT_CYC (`CMB_TXD_TIMEOUT_US * `CMB_CLK_MHZ)

// Pin synchroniser filter length.
`define CMB_SYNC_CYC 1

// Register byte offsets.
`define CMB_OFF_CTRL 12'h000
`define CMB_OFF_STATUS 12'h004
`define CMB_OFF_DIAG 12'h008

// Control register field positions and reset value.
`define CMB_CTRL_NOT_STANDBY 3
`define CMB_CTRL_TX_ENABLE 2
`define CMB_CTRL_WAKE_CLR 1
`define CMB_CTRL_RESET 3'h0

// Operation modes.
`define CMB_MODE_NORMAL 2'h0
`define CMB_MODE_RXONLY 2'h1
`define CMB_MODE_STANDBY 2'h2
`define CMB_MODE_SLEEP 2'h3
`define CMB_MODE_RESET 2'h2

// Receive multiplexer selections.
`define CMB_MUX_DIFF 2'h0
`define CMB_MUX_HIGH 2'h1
`define CMB_MUX_LOW 2'h2

// Bus responses.
`define CMB_RESP_OKAY 2'h0
`define CMB_RESP_SLVERR 2'h2

`endif

/* File: cmb_fail_filter.v */
// Three-stage synchroniser followed by an asymmetric on/off delay filter.
`timescale 1ns/100ps
module cmb_fail_filter #(
  parameter CW = 16,
  parameter [CW-1:0] ON_CYC = 16'h0001,
  parameter [CW-1:0] OFF_CYC = 16'h0001,
  parameter INIT = 1'b0
) (
  // Clock, reset and enable
  input wire clk_sys,
  input wire rst_b,
  input wire clk_en,
  // Raw level and filtered level
  input wire raw_in,
  output reg filt_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg [CW-1:0] cnt_reg;
  wire [CW-1:0] lim;

  assign lim = filt_out ? OFF_CYC : ON_CYC;

  // A new level is only taken once it has stood agreed for the full delay.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      cnt_reg <= {CW{1'b0}};
      filt_out <= INIT;
    end else if (clk_en) begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg && s3_reg != filt_out) begin
        if (cnt_reg >= lim - {{(CW-1){1'b0}}, 1'b1}) begin
          filt_out <= s3_reg;
          cnt_reg <= {CW{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
        end
      end else begin
        cnt_reg <= {CW{1'b0}};
      end
    end
  end

endmodule

/* File: cmb_proto_model.sv */
// Behavioural CAN protocol controller that sends short frames on txd.
`timescale 1ns/100ps
module cmb_proto_model #(
  parameter BIT_CYC = 4
) (
  // Clock and commands
  input wire clk_sys,
  input wire send,
  input wire stuck_dom,
  // Transmit data, low is dominant
  output reg txd
);
  // Frame starts dominant and never holds one level long enough to trip the timeout.
  localparam [7:0] FRAME = 8'hca;
  reg busy_reg = 1'b0;
  reg [5:0] cnt_reg = 6'h00;
  always @(posedge clk_sys) begin
    if (send && !busy_reg) begin
      busy_reg <= 1'b1;
      cnt_reg <= 6'h00;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg == 8 * BIT_CYC - 1) busy_reg <= 1'b0;
    end
  end
  always @* txd = stuck_dom ? 1'b0 : (busy_reg ? FRAME[cnt_reg / BIT_CYC] : 1'b1);
endmodule
